/* common/fcsc_defines.svh */
// Offsets, field positions, reset values and response codes of the flash cache control block
`ifndef FCSC_DEFINES_SVH
`define FCSC_DEFINES_SVH
`define FCSC_PLATFORM_CONTROL_OFS 32'h0000000C
`define FCSC_STALL_BIT            16
`define FCSC_SPEC_DIS_BIT         15
`define FCSC_DSPEC_EN_BIT         14
`define FCSC_CACHE_DIS_BIT        13
`define FCSC_ICACHE_DIS_BIT       12
`define FCSC_DCACHE_DIS_BIT       11
`define FCSC_INVAL_BIT            10
`define FCSC_CTL_RESET            6'h00
`define FCSC_RESP_OKAY            2'h0
`define FCSC_RESP_SLVERR          2'h2
`endif

/* common/fcsc_pkg.sv */
// Types shared by the flash cache control block and its bench
package fcsc_pkg;
  // Stored control bits, ordered as bits 16 down to 11 of the register
  typedef struct packed {
    logic stall_on_busy_enable;
    logic speculation_disable;
    logic data_speculation_enable;
    logic cache_disable;
    logic instr_cache_disable;
    logic data_cache_disable;
  } fcsc_ctl_s;
  // Decoded enables toward the flash controller
  typedef struct packed {
    logic spec_instr;
    logic spec_data;
    logic cache_instr;
    logic cache_data;
    logic stall_enable;
  } fcsc_en_s;
  // Write channel states
  typedef enum logic [3:0] {
    FCSC_WS_IDLE = 4'h1,
    FCSC_WS_ADDR = 4'h2,
    FCSC_WS_DATA = 4'h4,
    FCSC_WS_RESP = 4'h8
  } fcsc_wstate_e;
endpackage

/* hdl/fcsc_ctrl.sv */
// Flash speculation, cache and stall control register with an AXI4-Lite slave
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/10ps
`include "fcsc_defines.svh"

// Notes on behaviour
// (RULE1) Speculation and cache configuration lives in bits 15 to 10 of the control register.
// (RULE2) After reset speculation is on for instruction fetches and off for data fetches.
// (RULE3) Unless disabled, speculation always covers instructions and covers data when enabled.
// (RULE4) The speculation disable bit turns speculation fully off regardless of data enable.
// (RULE5) After reset the cache is on and caches both instruction and data fetches.
// (RULE6) Cache disable kills the cache; otherwise each fetch kind has its own disable bit.
// (RULE7) Bit 16 set makes accesses stall while the flash is busy; clear means no stalling.
// (RULE8) Software running under a flash operation executes from another sector.
// (RULE9) Software sets bit 16 just before a flash operation and clears it afterwards.
// (RULE10) Bits 31 to 17 are reserved, read-only and read as zero.
// (RULE11) Speculation disable sits at bit 15 and data speculation enable at bit 14.
// (RULE12) Data speculation enable at zero disables and at one enables data speculation.
// (RULE13) Cache disable is bit 13, instruction caching disable 12, data caching disable 11.
// (RULE14) Writing one to bit 10 invalidates the cache, zero does nothing, it reads as zero.
// (RULE15) Only privileged writes change the register; user writes leave it unchanged.
// (RULE16) Reserved write bits are dropped and enables follow the stored bits continuously.
module fcsc_ctrl #(
  parameter int ADDR_W = 12
) (
  // Clock, reset and enable
  input  wire logic                 clk_i,
  input  wire logic                 srst_i,
  input  wire logic                 ce_i,
  // AXI4-Lite write address
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic [2:0]           s_axi_awprot,
  // AXI4-Lite write data
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  // AXI4-Lite write response
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  output logic [1:0]                s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  input  wire logic [ADDR_W-1:0]    s_axi_araddr,
  input  wire logic [2:0]           s_axi_arprot,
  // AXI4-Lite read data
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  // Flash controller side
  input  wire logic                 flash_busy_i,
  output fcsc_pkg::fcsc_en_s        fc_enables_o,
  output logic                      cache_invalidate_o,
  output logic                      fc_stall_o
);
  import fcsc_pkg::*;

  localparam logic [ADDR_W-1:0] REG_OFS = ADDR_W'(`FCSC_PLATFORM_CONTROL_OFS);

  // Address decode shared by the read and write paths
  function automatic logic fcsc_hit(input logic [ADDR_W-1:0] a);
    fcsc_hit = (a[ADDR_W-1:2] == REG_OFS[ADDR_W-1:2]);
  endfunction

  fcsc_wstate_e     wstate_r;
  fcsc_wstate_e     wstate_nxt;
  fcsc_ctl_s        ctl_r;
  fcsc_ctl_s        ctl_nxt;
  fcsc_en_s         en_nxt;
  logic [ADDR_W-1:0] awaddr_r;
  logic             awpriv_r;
  logic [31:0]      wdata_r;
  logic [3:0]       wstrb_r;
  logic             aw_fire;
  logic             w_fire;
  logic             ar_fire;
  logic             wr_go;
  logic [ADDR_W-1:0] wr_addr;
  logic             wr_priv;
  logic [31:0]      wr_data;
  logic [3:0]       wr_strb;
  logic             wr_hit;
  logic             wr_ok;
  logic             inval_nxt;
  logic [31:0]      rd_word;

  // Channel handshakes
  assign aw_fire = ce_i & s_axi_awvalid & s_axi_awready;
  assign w_fire  = ce_i & s_axi_wvalid & s_axi_wready;
  assign ar_fire = ce_i & s_axi_arvalid & s_axi_arready;

  // Write channel sequencing: address and data accepted in either order
  always_comb begin
    wstate_nxt = wstate_r;
    case (wstate_r)
      FCSC_WS_IDLE: begin
        if (aw_fire && w_fire) begin
          wstate_nxt = FCSC_WS_RESP;
        end else if (aw_fire) begin
          wstate_nxt = FCSC_WS_ADDR;
        end else if (w_fire) begin
          wstate_nxt = FCSC_WS_DATA;
        end
      end
      FCSC_WS_ADDR: begin
        if (w_fire) begin
          wstate_nxt = FCSC_WS_RESP;
        end
      end
      FCSC_WS_DATA: begin
        if (aw_fire) begin
          wstate_nxt = FCSC_WS_RESP;
        end
      end
      FCSC_WS_RESP: begin
        if (ce_i && s_axi_bready) begin
          wstate_nxt = FCSC_WS_IDLE;
        end
      end
      default: begin
        wstate_nxt = FCSC_WS_IDLE;
      end
    endcase
  end

  // Write is committed on the edge where both halves are held
  assign wr_go   = (wstate_r != FCSC_WS_RESP) && (wstate_nxt == FCSC_WS_RESP);
  assign wr_addr = aw_fire ? s_axi_awaddr : awaddr_r;
  assign wr_priv = aw_fire ? s_axi_awprot[0] : awpriv_r;
  assign wr_data = w_fire ? s_axi_wdata : wdata_r;
  assign wr_strb = w_fire ? s_axi_wstrb : wstrb_r;
  assign wr_hit  = fcsc_hit(wr_addr);
  assign wr_ok   = wr_go & wr_hit & wr_priv; // RULE15

  // Field merge honouring byte strobes; reserved write bits are dropped
  assign ctl_nxt.stall_on_busy_enable =
    (wr_ok && wr_strb[2]) ? wr_data[`FCSC_STALL_BIT] : ctl_r.stall_on_busy_enable; // RULE7
  assign ctl_nxt.speculation_disable =
    (wr_ok && wr_strb[1]) ? wr_data[`FCSC_SPEC_DIS_BIT] : ctl_r.speculation_disable; // RULE11
  assign ctl_nxt.data_speculation_enable =
    (wr_ok && wr_strb[1]) ? wr_data[`FCSC_DSPEC_EN_BIT] : ctl_r.data_speculation_enable;
  assign ctl_nxt.cache_disable =
    (wr_ok && wr_strb[1]) ? wr_data[`FCSC_CACHE_DIS_BIT] : ctl_r.cache_disable; // RULE13
  assign ctl_nxt.instr_cache_disable =
    (wr_ok && wr_strb[1]) ? wr_data[`FCSC_ICACHE_DIS_BIT] : ctl_r.instr_cache_disable;
  assign ctl_nxt.data_cache_disable =
    (wr_ok && wr_strb[1]) ? wr_data[`FCSC_DCACHE_DIS_BIT] : ctl_r.data_cache_disable;
  assign inval_nxt = wr_ok & wr_strb[1] & wr_data[`FCSC_INVAL_BIT]; // RULE14

  // Decoded enables from the next stored value, so outputs track the register
  assign en_nxt.spec_instr   = ~ctl_nxt.speculation_disable; // RULE3 RULE4
  assign en_nxt.spec_data    = ~ctl_nxt.speculation_disable
                               & ctl_nxt.data_speculation_enable; // RULE12
  assign en_nxt.cache_instr  = ~ctl_nxt.cache_disable & ~ctl_nxt.instr_cache_disable; // RULE6
  assign en_nxt.cache_data   = ~ctl_nxt.cache_disable & ~ctl_nxt.data_cache_disable; // RULE6
  assign en_nxt.stall_enable = ctl_nxt.stall_on_busy_enable; // RULE16

  // Read word: reserved bits and the invalidate bit read as zero
  assign rd_word = {15'h0000, ctl_r, 1'b0, 10'h000}; // RULE1 RULE10

  // Control register and flash-side outputs
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ctl_r              <= `FCSC_CTL_RESET; // RULE2 RULE5
      // Instruction speculation and both cache kinds on, data speculation and stall off
      fc_enables_o       <= fcsc_en_s'(5'h16); // RULE2 RULE5
      cache_invalidate_o <= 1'b0;
      fc_stall_o         <= 1'b0;
    end else if (ce_i) begin
      ctl_r              <= ctl_nxt;
      fc_enables_o       <= en_nxt;
      cache_invalidate_o <= inval_nxt;
      fc_stall_o         <= ctl_r.stall_on_busy_enable & flash_busy_i; // RULE7
    end
  end

  // Write channel registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wstate_r      <= FCSC_WS_IDLE;
      awaddr_r      <= '0;
      awpriv_r      <= 1'b0;
      wdata_r       <= 32'h00000000;
      wstrb_r       <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `FCSC_RESP_OKAY;
    end else if (ce_i) begin
      wstate_r      <= wstate_nxt;
      awaddr_r      <= wr_addr;
      awpriv_r      <= wr_priv;
      wdata_r       <= wr_data;
      wstrb_r       <= wr_strb;
      s_axi_awready <= (wstate_nxt == FCSC_WS_IDLE) || (wstate_nxt == FCSC_WS_DATA);
      s_axi_wready  <= (wstate_nxt == FCSC_WS_IDLE) || (wstate_nxt == FCSC_WS_ADDR);
      s_axi_bvalid  <= (wstate_nxt == FCSC_WS_RESP);
      if (wr_go) begin
        s_axi_bresp <= wr_hit ? `FCSC_RESP_OKAY : `FCSC_RESP_SLVERR;
      end
    end
  end

  // Read channel: one outstanding read, answered the cycle after acceptance
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `FCSC_RESP_OKAY;
    end else if (ce_i) begin
      if (ar_fire) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= fcsc_hit(s_axi_araddr) ? rd_word : 32'h00000000;
        s_axi_rresp   <= fcsc_hit(s_axi_araddr) ? `FCSC_RESP_OKAY : `FCSC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b0;
      end
    end
  end

  // Checks of the stored configuration, its decoded enables, the stall and invalidate outputs and the read channel
  property p_reset_spec;
    @(posedge clk_i) srst_i |=> fc_enables_o.spec_instr && !fc_enables_o.spec_data;
  endproperty
  a_reset_spec: assert property (p_reset_spec) else $error("speculation reset state wrong"); // RULE2

  property p_reset_cache;
    @(posedge clk_i) srst_i |=> fc_enables_o.cache_instr && fc_enables_o.cache_data;
  endproperty
  a_reset_cache: assert property (p_reset_cache) else $error("cache reset state wrong"); // RULE5

  property p_spec_off;
    @(posedge clk_i) disable iff (srst_i)
      ctl_r.speculation_disable |-> !fc_enables_o.spec_instr && !fc_enables_o.spec_data;
  endproperty
  a_spec_off: assert property (p_spec_off) else $error("speculation not off"); // RULE4

  property p_spec_on;
    @(posedge clk_i) disable iff (srst_i)
      !ctl_r.speculation_disable |->
        fc_enables_o.spec_instr && (fc_enables_o.spec_data == ctl_r.data_speculation_enable);
  endproperty
  a_spec_on: assert property (p_spec_on) else $error("speculation enables wrong"); // RULE3

  property p_cache_map;
    @(posedge clk_i) disable iff (srst_i)
      (fc_enables_o.cache_instr == !(ctl_r.cache_disable || ctl_r.instr_cache_disable))
      && (fc_enables_o.cache_data == !(ctl_r.cache_disable || ctl_r.data_cache_disable));
  endproperty
  a_cache_map: assert property (p_cache_map) else $error("cache enables wrong"); // RULE6

  property p_stall;
    @(posedge clk_i) disable iff (srst_i)
      ce_i |=> (fc_stall_o == ($past(ctl_r.stall_on_busy_enable) && $past(flash_busy_i)));
  endproperty
  a_stall: assert property (p_stall) else $error("stall output wrong"); // RULE7

  property p_user_write;
    @(posedge clk_i) disable iff (srst_i)
      (wr_go && !wr_priv) |=> $stable(ctl_r) && !cache_invalidate_o;
  endproperty
  a_user_write: assert property (p_user_write) else $error("user write took effect"); // RULE15

  property p_inval;
    @(posedge clk_i) disable iff (srst_i)
      (ce_i && wr_go && wr_hit && wr_priv && wr_strb[1] && wr_data[`FCSC_INVAL_BIT])
        |=> cache_invalidate_o
        ##1 (!cache_invalidate_o || $past(inval_nxt) || !$past(ce_i));
  endproperty
  a_inval: assert property (p_inval) else $error("invalidate pulse wrong"); // RULE14

  property p_read_zero;
    @(posedge clk_i) disable iff (srst_i)
      s_axi_rvalid |-> (s_axi_rdata[31:17] == 15'h0000) && !s_axi_rdata[`FCSC_INVAL_BIT];
  endproperty
  a_read_zero: assert property (p_read_zero) else $error("reserved read bits set"); // RULE10

  property p_read_latency;
    @(posedge clk_i) disable iff (srst_i)
      ar_fire |=> s_axi_rvalid ##0 !s_axi_arready;
  endproperty
  a_read_latency: assert property (p_read_latency) else $error("read answer late");

  // Stall enable output mirrors the stored bit at all times
  property p_stall_map;
    @(posedge clk_i) disable iff (srst_i)
      fc_enables_o.stall_enable == ctl_r.stall_on_busy_enable;
  endproperty
  a_stall_map: assert property (p_stall_map) else $error("stall enable wrong"); // RULE16

  // A committed write answers next cycle and blocks both write channels
  property p_write_resp;
    @(posedge clk_i) disable iff (srst_i)
      wr_go |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready;
  endproperty
  a_write_resp: assert property (p_write_resp) else $error("write answer wrong");

  // Main scenarios
  c_write_ctl: cover property (@(posedge clk_i) disable iff (srst_i) wr_ok ##1 s_axi_bvalid);
  c_invalidate: cover property (@(posedge clk_i) disable iff (srst_i) cache_invalidate_o);
  c_stall: cover property (@(posedge clk_i) disable iff (srst_i) fc_stall_o);
  c_user_write: cover property (@(posedge clk_i) disable iff (srst_i) wr_go && !wr_priv);
  c_spec_data: cover property (@(posedge clk_i) disable iff (srst_i) fc_enables_o.spec_data);

endmodule

/* tb/fcsc_ctrl_tb_top.sv */
// Self-checking bench for the flash cache control register block
`timescale 1ns/10ps
`include "fcsc_defines.svh"

module fcsc_ctrl_tb_top;
  import fcsc_pkg::*;

  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic ce_i = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, flash_busy_i = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  fcsc_en_s    fc_enables_o;
  logic        cache_invalidate_o, fc_stall_o;
  fcsc_ctl_s   ctl;
  int          error_cnt = 0, n_compared = 0, cyc = 0;

  fcsc_ctrl i_fcsc_ctrl (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awprot(s_axi_awprot), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .flash_busy_i(flash_busy_i), .fc_enables_o(fc_enables_o),
    .cache_invalidate_o(cache_invalidate_o), .fc_stall_o(fc_stall_o));

  // 20 MHz clock
  initial begin
    forever #25 clk_i = ~clk_i;
  end

  // Cuts a hung run short
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("errors=%0d compared=%0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Hand-picked corner words for the first writes
  function automatic logic [31:0] corner_word(input int i);
    case (i)
      0: return 32'h00001800;
      1: return 32'h0000A000;
      2: return 32'h00004000;
      default: return 32'hFFFFFFFF;
    endcase
  endfunction

  // Expected read word: stored bits at 16:11, everything else zero
  function automatic logic [31:0] exp_word(input fcsc_ctl_s c);
    return {15'h0000, c, 11'h000};
  endfunction

  // Expected decoded enables from the stored bits
  function automatic logic [31:0] exp_en(input fcsc_ctl_s c);
    fcsc_en_s e;
    e.spec_instr   = !c.speculation_disable;
    e.spec_data    = !c.speculation_disable && c.data_speculation_enable;
    e.cache_instr  = !c.cache_disable && !c.instr_cache_disable;
    e.cache_data   = !c.cache_disable && !c.data_cache_disable;
    e.stall_enable = c.stall_on_busy_enable;
    return {27'h0, e};
  endfunction

  // Write: address and data offered together, bready held until bvalid seen
  task automatic axi_wr(input logic [11:0] a, input logic [2:0] p, input logic [31:0] d,
                        input logic [3:0] s, output logic [1:0] resp, output logic inv);
    s_axi_awvalid <= 1'b1; s_axi_awaddr <= a; s_axi_awprot <= p;
    s_axi_wvalid <= 1'b1; s_axi_wdata <= d; s_axi_wstrb <= s; s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      resp = s_axi_bresp;
      inv = cache_invalidate_o;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
    s_axi_arvalid <= 1'b1; s_axi_araddr <= a; s_axi_arprot <= 3'($urandom); s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      d = s_axi_rdata;
      resp = s_axi_rresp;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask

  // Read the register back and compare word and enables
  task automatic check_all();
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(12'h00C, d, r);
    chk(d, exp_word(ctl));
    chk({30'h0, r}, {30'h0, `FCSC_RESP_OKAY});
    chk({27'h0, fc_enables_o}, exp_en(ctl));
  endtask

  initial begin
    logic [31:0] d, rd;
    logic [11:0] a;
    logic [3:0]  s;
    logic [2:0]  p;
    logic [1:0]  r;
    logic        inv, b;
    void'($urandom(32'h77196066));
    repeat (8) @(posedge clk_i);
    srst_i <= 1'b0;
    ctl = fcsc_ctl_s'(`FCSC_CTL_RESET);
    @(posedge clk_i);
    chk({27'h0, fc_enables_o}, 32'h00000016);
    check_all();
    // Corner words, then random traffic with user, unmapped and partial-lane writes
    for (int i = 0; i < 60; i++) begin
      d = (i < 4) ? corner_word(i) : $urandom;
      s = (i < 4) ? 4'hF : 4'($urandom);
      p = (i < 4) ? 3'h1 : 3'($urandom);
      a = (i % 7 == 6) ? ((i % 2) ? 12'h008 : 12'h010) : 12'h00C;
      axi_wr(a, p, d, s, r, inv);
      chk({30'h0, r}, (a == 12'h00C) ? 32'h0 : {30'h0, `FCSC_RESP_SLVERR});
      if (a == 12'h00C && p[0]) begin
        if (s[2]) ctl.stall_on_busy_enable = d[16];
        if (s[1]) ctl[4:0] = d[15:11];
      end
      chk({31'h0, inv}, {31'h0, a == 12'h00C && p[0] && s[1] && d[10]});
      check_all();
      chk({27'h0, fc_enables_o}, exp_en(ctl));
    end
    // Unmapped read answers error with zero data
    @(posedge clk_i);
    axi_rd(12'h004, rd, r);
    chk(rd, 32'h0);
    chk({30'h0, r}, {30'h0, `FCSC_RESP_SLVERR});
    // Stall follows busy only while enabled; set before the operation, cleared after it
    for (int k = 0; k < 3; k++) begin
      axi_wr(12'h00C, 3'h1, {15'h0, k[0], 16'h0}, 4'hF, r, inv);
      ctl = fcsc_ctl_s'({k[0], 5'h00});
      for (int j = 0; j < 12; j++) begin
        b = 1'($urandom);
        flash_busy_i <= b;
        @(posedge clk_i);
        @(posedge clk_i);
        chk({31'h0, fc_stall_o}, {31'h0, k[0] & b});
      end
    end
    // Clock enable low freezes the stall output
    axi_wr(12'h00C, 3'h1, 32'h00010000, 4'hF, r, inv);
    flash_busy_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    ce_i <= 1'b0;
    flash_busy_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk({31'h0, fc_stall_o}, 32'h00000001);
    ce_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk({31'h0, fc_stall_o}, 32'h00000000);
    // Mid-run reset returns defaults
    axi_wr(12'h00C, 3'h1, 32'h0001F800, 4'hF, r, inv);
    srst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    ctl = fcsc_ctl_s'(`FCSC_CTL_RESET);
    @(posedge clk_i);
    check_all();
    report_and_stop();
  end
endmodule
